//--- pamx_board.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Board pins
// ----
module pamx_board (
    input  wire pamx_pkg::pamx_pin_drv_t drv_a,
    input  wire pamx_pkg::pamx_pin_drv_t drv_b,
    input  wire pamx_pkg::pamx_pin_drv_t drv_c,
    input  wire logic                    pin_d0_out,
    input  wire logic                    pin_d0_oe,
    input  wire logic                    pin_d0_pullup,
    input  wire logic [7:0]              ext_a,
    input  wire logic [7:0]              ext_b,
    input  wire logic                    ext_d0_low,
    output logic [7:0]                   pin_a_in,
    output logic [7:0]                   pin_b_in,
    output logic [7:0]                   pin_c_in,
    output logic                         pin_d0_in
);
    // Driven bits follow the chip, others the board sources
    assign pin_a_in = (drv_a.oe & drv_a.out) | (~drv_a.oe & ext_a);
    assign pin_b_in = (drv_b.oe & drv_b.out) | (~drv_b.oe & ext_b);
    // Floating port C bits show the inverse, never a stale copy
    assign pin_c_in = drv_c.out ^ ~drv_c.oe;
    // Open drain: any low beats the pull-up
    assign pin_d0_in = !(pin_d0_oe && !pin_d0_out) && !ext_d0_low && (pin_d0_oe || pin_d0_pullup);
endmodule : pamx_board
`default_nettype wire

//--- pamx_mux.sv
`timescale 1ns/1ps
`default_nettype none
`include "pamx_regs.svh"
module pamx_mux (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire pamx_pkg::pamx_port_cfg_t cfg_a,
    input  wire pamx_pkg::pamx_port_cfg_t cfg_b,
    input  wire pamx_pkg::pamx_port_cfg_t cfg_c,
    input  wire pamx_pkg::pamx_port_cfg_t cfg_d,
    input  wire logic                     cfg_a_wr,
    input  wire logic                     cfg_d_wr,
    input  wire logic [15:0]              led_level,
    input  wire logic [7:0]               led_sink_enable,
    input  wire logic                     xtal_enable,
    input  wire logic                     timer_out_mode,
    input  wire logic                     timer_out_a,
    input  wire logic                     timer_out_b,
    input  wire logic                     reset_req,
    input  wire logic [7:0]               pin_a_in,
    input  wire logic [7:0]               pin_b_in,
    input  wire logic [7:0]               pin_c_in,
    input  wire logic                     pin_d0_in,
    output pamx_pkg::pamx_pin_drv_t       drv_a,
    output pamx_pkg::pamx_pin_drv_t       drv_b,
    output pamx_pkg::pamx_pin_drv_t       drv_c,
    output logic                          pin_d0_out,
    output logic                          pin_d0_oe,
    output logic                          pin_d0_pullup,
    output logic                          pin_d0_high_drive,
    output logic [7:0]                    led_sink_on,
    output logic [15:0]                   led_sink_level,
    output logic [7:0]                    gpio_a_in,
    output logic [7:0]                    gpio_b_in,
    output logic [7:0]                    gpio_c_in,
    output logic                          ext_reset_in,
    output logic                          timer_in_a,
    output logic                          timer_in_b,
    output logic [5:0]                    analog_sel,
    output logic                          vref_sel,
    output logic                          external_clock_input,
    output logic [7:0]                    stop_wake_mask_a,
    output logic [7:0]                    set_select_high_b,
    output logic [7:0]                    set_select_high_c
);
    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [24:0] sync_1;
    logic [24:0] sync_2;
    logic [7:0]  pa_s;
    logic [7:0]  pb_s;
    logic [7:0]  pc_s;
    logic        pd_s;

    // Pins are asynchronous to clk_sys; a single stage
    // would let metastability reach the muxes.
    // Cost: three edges from a pin to any input output.
    // No reset here; stale samples flush in two edges.
    // Two stages before any logic sees a pin
    always_ff @(posedge clk_sys) begin
        sync_1 <= {pin_d0_in, pin_c_in, pin_b_in, pin_a_in};
        sync_2 <= sync_1;
    end
    assign {pd_s, pc_s, pb_s, pa_s} = sync_2;

    // ----------------------------------------
    // Shared reset pin role
    // ----------------------------------------
    logic reset_role;

    // Flag only moves on a write strobe, so a stray
    // level on the port D alt enable cannot drop the role.
    // Writing alt enable 1 again restores the reset role.
    // Role survives every other configuration change.
    // Reset role held until software clears the alt enable of bit 0
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reset_role <= 1'b1;
        end else if (cfg_d_wr) begin
            reset_role <= cfg_d.alt_en[`PAMX_RSTPIN_BIT];
        end
    end

    // Pull-up stays on in reset role so an idle line reads high.
    // Port D stop-wake bits are never routed: no wake source.
    // Direction bit ignored in general mode; pin is output only.
    // High drive follows software in both roles.
    // Reset role open drain: only drive low; general mode is output only
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_d0_out        <= 1'b0;
            pin_d0_oe         <= 1'b0;
            pin_d0_pullup     <= 1'b1;
            pin_d0_high_drive <= 1'b0;
            ext_reset_in      <= 1'b0;
        end else begin
            pin_d0_high_drive <= cfg_d.high_drive[`PAMX_RSTPIN_BIT];
            if (reset_role) begin
                pin_d0_out    <= 1'b0;
                pin_d0_oe     <= reset_req;
                pin_d0_pullup <= 1'b1;
                ext_reset_in  <= ~pd_s;
            end else begin
                pin_d0_out    <= cfg_d.out_data[`PAMX_RSTPIN_BIT];
                pin_d0_oe     <= 1'b1;
                pin_d0_pullup <= 1'b0;
                ext_reset_in  <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Port A: timer pair and crystal override
    // ----------------------------------------
    logic [7:0] next_a_out;
    logic [7:0] next_a_oe;
    logic [7:0] xtal_mask;

    assign xtal_mask = xtal_enable ? 8'h03 : 8'h00;

    // Both timer pins share one configuration; only the
    // timer mode decides input or output path.
    // Crystal mask applied last so nothing leaks onto crystal pins.
    // Limitation: timer input on bit 0 is lost under crystal.
    // Alt enable hands timer pins to the timer; its mode picks direction
    always_comb begin
        next_a_out = cfg_a.out_data;
        next_a_oe  = ~cfg_a.dir_in;
        if (cfg_a.alt_en[`PAMX_TMR_PIN_A]) begin
            next_a_out[`PAMX_TMR_PIN_A] = timer_out_a;
            next_a_oe[`PAMX_TMR_PIN_A]  = timer_out_mode;
        end
        if (cfg_a.alt_en[`PAMX_TMR_PIN_B]) begin
            next_a_out[`PAMX_TMR_PIN_B] = timer_out_b;
            next_a_oe[`PAMX_TMR_PIN_B]  = timer_out_mode;
        end
        next_a_oe  = next_a_oe & ~xtal_mask;
        next_a_out = next_a_out & ~xtal_mask;
    end

    // Registered pin drive: outputs come straight from flops.
    // Crystal pins also drop out of input, drive and wake paths.
    // Timer input gating mirrors the output-side selection.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            drv_a            <= '0;
            gpio_a_in        <= 8'h00;
            timer_in_a       <= 1'b0;
            timer_in_b       <= 1'b0;
            stop_wake_mask_a <= 8'h00;
        end else begin
            drv_a.out        <= next_a_out;
            drv_a.oe         <= next_a_oe;
            drv_a.high_drive <= cfg_a.high_drive & ~xtal_mask;
            gpio_a_in        <= pa_s & ~xtal_mask;
            timer_in_a       <= cfg_a.alt_en[`PAMX_TMR_PIN_A] & ~timer_out_mode & ~xtal_enable
                                & pa_s[`PAMX_TMR_PIN_A];
            timer_in_b       <= cfg_a.alt_en[`PAMX_TMR_PIN_B] & ~timer_out_mode & pa_s[`PAMX_TMR_PIN_B];
            stop_wake_mask_a <= cfg_a.stop_wake_en & ~xtal_mask;
        end
    end

    // ----------------------------------------
    // Port B: set-select choice of analog or clock input
    // ----------------------------------------
    logic [7:0] b_alt;

    // Pins 6 and 7 have nothing to select, so alt enable is ignored there
    assign b_alt = cfg_b.alt_en & 8'h3f;

    // Set-select low picks the function; high is stored only.
    // Pin 4 maps to the analog channel four input.
    // Pin 5 goes to the reference select, not analog_sel.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            drv_b                <= '0;
            gpio_b_in            <= 8'h00;
            analog_sel           <= 6'h00;
            vref_sel             <= 1'b0;
            external_clock_input <= 1'b0;
            set_select_high_b    <= 8'h00;
        end else begin
            // Alt-enabled pins 0 to 5 are released; analog and clock are inputs
            drv_b.out            <= cfg_b.out_data;
            drv_b.oe             <= ~cfg_b.dir_in & ~b_alt;
            drv_b.high_drive     <= cfg_b.high_drive;
            gpio_b_in            <= pb_s & ~b_alt;
            analog_sel           <= 6'((b_alt & cfg_b.set_low) & 8'h1f);
            vref_sel             <= b_alt[`PAMX_VREF_PIN] & cfg_b.set_low[`PAMX_VREF_PIN];
            external_clock_input <= b_alt[`PAMX_EXTERNAL_CLOCK_INPUT_PIN] & ~cfg_b.set_low[`PAMX_EXTERNAL_CLOCK_INPUT_PIN]
                                    & pb_s[`PAMX_EXTERNAL_CLOCK_INPUT_PIN];
            set_select_high_b    <= cfg_b.set_high;
        end
    end

    // ----------------------------------------
    // Port C: LED sink over everything else
    // ----------------------------------------
    // LED sink takes the pin from the GPIO driver outright.
    // Level pairs: pin n at bits 2n+1 down to 2n.
    // Trade-off: input path left open so software can read pins.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            drv_c             <= '0;
            gpio_c_in         <= 8'h00;
            led_sink_on       <= `PAMX_LED_RST;
            led_sink_level    <= 16'h0000;
            set_select_high_c <= 8'h00;
        end else begin
            // Sink pins are removed from the GPIO driver, whatever alt says
            drv_c.out         <= cfg_c.out_data;
            drv_c.oe          <= ~cfg_c.dir_in & ~cfg_c.alt_en & ~led_sink_enable;
            drv_c.high_drive  <= cfg_c.high_drive;
            gpio_c_in         <= pc_s;
            led_sink_on       <= led_sink_enable;
            led_sink_level    <= led_level;
            set_select_high_c <= cfg_c.set_high;
        end
    end
endmodule : pamx_mux
`default_nettype wire

//--- pamx_mux_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Pin mux checker
// ----
module pamx_mux_monitor (
    input wire logic                     clk_sys,
    input wire logic                     rst,
    input wire pamx_pkg::pamx_port_cfg_t cfg_a,
    input wire pamx_pkg::pamx_port_cfg_t cfg_b,
    input wire pamx_pkg::pamx_port_cfg_t cfg_d,
    input wire logic                     cfg_d_wr,
    input wire logic                     xtal_enable,
    input wire logic                     timer_out_mode,
    input wire logic                     timer_out_a,
    input wire logic                     reset_req,
    input wire pamx_pkg::pamx_pin_drv_t  drv_a,
    input wire logic                     pin_d0_out,
    input wire logic                     pin_d0_oe,
    input wire logic                     pin_d0_pullup,
    input wire logic [5:0]               analog_sel
);
    // Shadow of the D0 role flag, so role checks need no body access
    logic role;
    always_ff @(posedge clk_sys) begin
        if (rst) role <= 1'b1;
        else if (cfg_d_wr) role <= cfg_d.alt_en[0];
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_leave_role;
        cfg_d_wr && !cfg_d.alt_en[0] ##1 !cfg_d_wr;
    endsequence
    AST_XTAL: assert property (xtal_enable |=> drv_a.oe[1:0] == 2'h0)
        else $error("crystal pins driven");
    AST_TMR_OUT: assert property (cfg_a.alt_en[0] && timer_out_mode && !xtal_enable |=> drv_a.oe[0] && drv_a.out[0] == $past(timer_out_a))
        else $error("timer output not on pin");
    AST_TMR_IN: assert property (cfg_a.alt_en[6] && !timer_out_mode |=> !drv_a.oe[6])
        else $error("timer input pin driven");
    AST_ANALOG: assert property (1'b1 |=> analog_sel[4:0] == $past(cfg_b.alt_en[4:0] & cfg_b.set_low[4:0]))
        else $error("analog select wrong");
    AST_GPIO: assert property (!cfg_a.alt_en[2] |=> drv_a.oe[2] != $past(cfg_a.dir_in[2]))
        else $error("gpio direction wrong");
    AST_D0_RESET: assert property (role && reset_req |=> pin_d0_oe && !pin_d0_out)
        else $error("reset pin not pulled low");
    AST_D0_PULL: assert property (role |=> pin_d0_pullup)
        else $error("reset pin pull-up off");
    AST_D0_GPIO: assert property (s_leave_role |=> pin_d0_oe && !pin_d0_pullup)
        else $error("d0 not an output");
endmodule : pamx_mux_monitor
bind pamx_mux pamx_mux_monitor pamx_mux_monitor_inst (.*);
`default_nettype wire

//--- pamx_pkg.sv
package pamx_pkg;
    // LED sink level per pin: 3, 7, 13, 20 mA
    typedef enum logic [1:0] {
        PAMX_LED_3MA  = 2'h0,
        PAMX_LED_7MA  = 2'h1,
        PAMX_LED_13MA = 2'h2,
        PAMX_LED_20MA = 2'h3
    } pamx_led_lvl_t;

    // Per-port software configuration
    typedef struct packed {
        logic [7:0] out_data;
        logic [7:0] dir_in;
        logic [7:0] alt_en;
        logic [7:0] set_low;
        logic [7:0] set_high;
        logic [7:0] high_drive;
        logic [7:0] stop_wake_en;
    } pamx_port_cfg_t;

    // Per-port pin drive bundle
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] high_drive;
    } pamx_pin_drv_t;
endpackage : pamx_pkg

//--- pamx_regs.svh
`ifndef PAMX_REGS_SVH
`define PAMX_REGS_SVH

// ----------------------------------------
// Reset values and pin positions
// ----------------------------------------
`define PAMX_AF_RST_ABC     8'h00
`define PAMX_AF_RST_D       8'h01
`define PAMX_DIR_RST        8'hff
`define PAMX_LED_RST        8'h00
`define PAMX_TMR_PIN_A      0
`define PAMX_TMR_PIN_B      6
`define PAMX_XTAL_PIN_A     0
`define PAMX_XTAL_PIN_B     1
`define PAMX_EXTERNAL_CLOCK_INPUT_PIN      3
`define PAMX_VREF_PIN       5
`define PAMX_ANA_PINS       6
`define PAMX_RSTPIN_BIT     0
`endif

//--- tb_port_alternate_function_mux.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Pin mux bench
// ----
module tb_port_alternate_function_mux;
    logic                     clk_sys, rst, cfg_a_wr, cfg_d_wr, xtal_enable, timer_out_mode, timer_out_a, timer_out_b;
    logic                     reset_req, ext_d0_low, pin_d0_in, pin_d0_out, pin_d0_oe, pin_d0_pullup, pin_d0_high_drive;
    logic                     ext_reset_in, timer_in_a, timer_in_b, vref_sel, external_clock_input;
    logic [5:0]               analog_sel;
    logic [7:0]               led_sink_enable, led_sink_on, ext_a, ext_b, pin_a_in, pin_b_in, pin_c_in;
    logic [7:0]               gpio_a_in, gpio_b_in, gpio_c_in, stop_wake_mask_a, set_select_high_b, set_select_high_c;
    logic [15:0]              led_level, led_sink_level;
    pamx_pkg::pamx_port_cfg_t cfg_a, cfg_b, cfg_c, cfg_d;
    pamx_pkg::pamx_pin_drv_t  drv_a, drv_b, drv_c;
    int                       failures, samples_checked;
    pamx_mux pamx_mux_inst (.*);
    pamx_board pamx_board_inst (.*);
    // 20 ns clock
    initial begin
        clk_sys = 1'h0;
        forever #10 clk_sys = ~clk_sys;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // Falling-edge steps keep drives off the sampling edge
    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : cyc
    task automatic results;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    task automatic t_shared_reset;
        check("d0_role", {pin_d0_oe, pin_d0_pullup}, 2'h1);
        reset_req = 1'h1;
        cyc(6);
        check("d0_reset", {pin_d0_oe, pin_d0_out, ext_reset_in}, 3'h5);
        reset_req = 1'h0;
        cfg_d.dir_in = 8'hfe;
        cfg_d.out_data = 8'h01;
        cfg_d.high_drive = 8'h01;
        cfg_d.alt_en = 8'h00;
        cfg_d_wr = 1'h1;
        cyc(1);
        cfg_d_wr = 1'h0;
        cyc(2);
        check("d0_gpio", {pin_d0_oe, pin_d0_pullup, pin_d0_out, pin_d0_high_drive}, 4'hb);
    endtask : t_shared_reset
    task automatic t_timer_pins;
        cfg_a.dir_in = 8'h0f;
        cfg_a.out_data = 8'h50;
        cfg_a.alt_en = 8'h41;
        cfg_a.stop_wake_en = 8'hff;
        timer_out_mode = 1'h1;
        timer_out_a = 1'h1;
        cyc(2);
        check("a_drive", {drv_a.oe, drv_a.out}, 16'hf111);
        timer_out_mode = 1'h0;
        ext_a = 8'h41;
        cyc(6);
        check("a6_in", {drv_a.oe[6], timer_in_b}, 2'h1);
        check("a0_in", {drv_a.oe[0], timer_in_a}, 2'h1);
        check("a_gpio", gpio_a_in, 8'h51);
        timer_out_mode = 1'h1;
        xtal_enable = 1'h1;
        cyc(2);
        check("xtal", drv_a.oe[1:0], 2'h0);
        check("xtal_wake", stop_wake_mask_a, 8'hfc);
        xtal_enable = 1'h0;
    endtask : t_timer_pins
    task automatic t_port_b;
        cfg_b.alt_en = 8'hff;
        cfg_b.dir_in = 8'h0f;
        cfg_b.set_low = 8'h2a;
        cfg_b.set_high = 8'hff;
        ext_b = 8'h08;
        cyc(6);
        check("b_sel1", {vref_sel, analog_sel[4:0], external_clock_input, set_select_high_b}, 15'h54ff);
        check("b_oe_alt", drv_b.oe, 8'hc0);
        cfg_b.set_low = 8'h15;
        cfg_b.set_high = 8'h00;
        cyc(2);
        check("b_sel2", {vref_sel, analog_sel[4:0], external_clock_input}, 7'h2b);
        cfg_b.alt_en = 8'h00;
        cyc(2);
        check("b_gpio", {vref_sel, analog_sel, external_clock_input}, 8'h00);
        check("b_oe", drv_b.oe, 8'hf0);
        check("b_in", gpio_b_in, 8'h08);
    endtask : t_port_b
    task automatic t_led_sink;
        led_sink_enable = 8'ha5;
        led_level = 16'h1be4;
        cfg_c.set_high = 8'h3c;
        cyc(2);
        check("led", {led_sink_on, set_select_high_c}, 16'ha53c);
        check("led_lvl", led_sink_level, 16'h1be4);
        check("c_oe", drv_c.oe, 8'h5a);
        cfg_c.alt_en = 8'hff;
        led_sink_enable = 8'h5a;
        cyc(2);
        check("led_alt", led_sink_on, 8'h5a);
        cyc(4);
        check("c_oe_alt", drv_c.oe, 8'h00);
        check("c_in", gpio_c_in, 8'hff);
    endtask : t_led_sink
    // Main sequence
    initial begin
        {cfg_a_wr, cfg_d_wr, xtal_enable, timer_out_mode, timer_out_a, timer_out_b, reset_req, ext_d0_low} = 8'h00;
        {led_level, led_sink_enable, ext_a, ext_b} = 40'h0;
        {cfg_a, cfg_b, cfg_c, cfg_d} = '0;
        cfg_b.dir_in = 8'hff;
        cfg_d.alt_en = 8'h01;
        failures = 0;
        samples_checked = 0;
        rst = 1'h1;
        cyc(16);
        rst = 1'h0;
        cyc(1);
        t_shared_reset();
        t_timer_pins();
        t_port_b();
        t_led_sink();
        results();
    end
    // Watchdog, far beyond the few dozen cycles the scenarios need
    initial begin
        repeat (2000) @(posedge clk_sys);
        failures++;
        results();
    end
endmodule : tb_port_alternate_function_mux
`default_nettype wire
